/* tcc_regs.sv */
/*
 Per-channel control and touch result register bank of a twelve channel
 capacitive touch sensor, with interrupt level compare and output mode pin.
 Assumes the serial interface logic presents byte accesses on req_i and
 the sensing core delivers channel results on the same clock.
*/
`timescale 1ns/1ps
`default_nettype none
module tcc_regs
   import tcc_pkg::*;
#(
   parameter int unsigned NCH = TCC_NCH
)
(
   input wire logic clock_i,
   input wire logic rst_i,
   input wire tcc_req_t req_i,
   input wire logic [23:0] sense_level_i,
   input wire logic [1:0] irq_level_select_i,
   input wire logic output_mode_pin_i,
   output logic [7:0] rdata_o,
   output logic [11:0] renew_o,
   output logic [11:0] sense_en_o,
   output logic [11:0] calib_en_o,
   output logic single_mode_o,
   output logic irq_o
);
   logic [11:0] renew_q;
   logic [11:0] renew_d;
   logic [11:0] shold_q;
   logic [11:0] shold_d;
   logic [11:0] chold_q;
   logic [11:0] chold_d;
   logic [23:0] level_q;
   logic [23:0] level_d;
   logic [7:0] rdata_q;
   logic [7:0] rdata_d;
   logic [11:0] sen_q;
   logic [11:0] sen_d;
   logic [11:0] cen_q;
   logic [11:0] cen_d;
   logic irq_q;
   logic irq_d;
   logic mode_q;
   logic mode_d;
   logic mode_lvl;

   // Level meets the chosen interrupt threshold
   function automatic logic level_hits(input logic [1:0] lvl, input logic [1:0] sel);
      logic hit;
      hit = 1'b0;
      case (sel)
         TCC_ILS_LOW: hit = (lvl != TCC_LVL_NONE);
         TCC_ILS_HIGH: hit = (lvl == TCC_LVL_HIGH);
         default: hit = (lvl == TCC_LVL_MID) || (lvl == TCC_LVL_HIGH);
      endcase
      return hit;
   endfunction : level_hits

   // Register read decode; upper control nibbles read zero
   function automatic logic [7:0] read_mux(input logic [7:0] a, input logic [11:0] rn,
      input logic [11:0] sh, input logic [11:0] ch, input logic [23:0] lv);
      logic [7:0] r;
      r = TCC_RD_UNMAPPED;
      case (a)
         TCC_ADDR_RENEW_LO: r = rn[7:0];
         TCC_ADDR_RENEW_HI: r = {4'h0, rn[11:8]};
         TCC_ADDR_SHOLD_LO: r = sh[7:0];
         TCC_ADDR_SHOLD_HI: r = {4'h0, sh[11:8]};
         TCC_ADDR_CHOLD_LO: r = ch[7:0];
         TCC_ADDR_CHOLD_HI: r = {4'h0, ch[11:8]};
         TCC_ADDR_LEVEL_A: r = lv[7:0];
         TCC_ADDR_LEVEL_B: r = lv[15:8];
         TCC_ADDR_LEVEL_C: r = lv[23:16];
         default: r = TCC_RD_UNMAPPED;
      endcase
      return r;
   endfunction : read_mux

   // Output mode pin is asynchronous to the core clock
   tcc_sync3 u_mode_sync (
      .clock_i(clock_i),
      .rst_i(rst_i),
      .pin_i(output_mode_pin_i),
      .level_o(mode_lvl)
   );

   // Control register writes
   always_comb
   begin
      renew_d = renew_q;
      shold_d = shold_q;
      chold_d = chold_q;
      if (req_i.wr)
      begin
         case (req_i.addr)
            TCC_ADDR_RENEW_LO: renew_d[7:0] = req_i.wdata;
            TCC_ADDR_RENEW_HI: renew_d[11:8] = req_i.wdata[3:0];
            TCC_ADDR_SHOLD_LO: shold_d[7:0] = req_i.wdata;
            TCC_ADDR_SHOLD_HI: shold_d[11:8] = req_i.wdata[3:0];
            TCC_ADDR_CHOLD_LO: chold_d[7:0] = req_i.wdata;
            TCC_ADDR_CHOLD_HI: chold_d[11:8] = req_i.wdata[3:0];
            default: ;
         endcase
      end
   end

   // Channel enables, result capture, interrupt and read data
   always_comb
   begin
      irq_d = 1'b0;
      level_d = level_q;
      sen_d = ~shold_q;
      cen_d = ~shold_q & ~chold_q;
      for (int i = 0; i < NCH; i++)
      begin
         if (shold_q[i])
         begin
            level_d[2*i +: 2] = TCC_LVL_NONE;
         end
         else
         begin
            level_d[2*i +: 2] = sense_level_i[2*i +: 2];
         end
         if (level_hits(level_q[2*i +: 2], irq_level_select_i))
         begin
            irq_d = 1'b1;
         end
      end
      mode_d = mode_lvl;
      rdata_d = rdata_q;
      if (req_i.rd)
      begin
         rdata_d = read_mux(req_i.addr, renew_q, shold_q, chold_q, level_q);
      end
   end

   // State registers; reset pin held high keeps everything at reset values
   always_ff @(posedge clock_i)
   begin
      if (rst_i)
      begin
         renew_q <= TCC_RST_RENEW;
         shold_q <= TCC_RST_SHOLD;
         chold_q <= TCC_RST_CHOLD;
         level_q <= TCC_RST_LEVEL;
         sen_q <= ~TCC_RST_SHOLD;
         cen_q <= ~TCC_RST_SHOLD;
         rdata_q <= TCC_RD_UNMAPPED;
         irq_q <= 1'b0;
         mode_q <= 1'b0;
      end
      else
      begin
         renew_q <= renew_d;
         shold_q <= shold_d;
         chold_q <= chold_d;
         level_q <= level_d;
         sen_q <= sen_d;
         cen_q <= cen_d;
         rdata_q <= rdata_d;
         irq_q <= irq_d;
         mode_q <= mode_d;
      end
   end

   assign rdata_o = rdata_q;
   assign renew_o = renew_q;
   assign sense_en_o = sen_q;
   assign calib_en_o = cen_q;
   assign single_mode_o = mode_q;
   assign irq_o = irq_q;

   default clocking cb @(posedge clock_i); endclocking
   default disable iff (rst_i);

   sequence s_rst_release;
      $fell(rst_i);
   endsequence

   AST_RENEW_WRITE: assert property (
      req_i.wr && req_i.addr == TCC_ADDR_RENEW_LO |=> renew_o[7:0] == $past(req_i.wdata))
      else $error("renewal low byte not stored");
   AST_RESET_VALUES: assert property (@(posedge clock_i) disable iff (1'b0)
      s_rst_release |-> renew_o == TCC_RST_RENEW && chold_q == TCC_RST_CHOLD)
      else $error("control reset values wrong");
   AST_HOLD_STOPS: assert property (
      shold_q[0] |=> !sense_en_o[0] && !calib_en_o[0])
      else $error("held channel still enabled");
   AST_SHOLD_RESET: assert property (@(posedge clock_i) disable iff (1'b0)
      s_rst_release |-> sense_en_o == ~TCC_RST_SHOLD)
      else $error("sensing hold reset value wrong");
   AST_CAL_HOLD: assert property (
      chold_q[1] && !shold_q[1] |=> sense_en_o[1] && !calib_en_o[1])
      else $error("calibration hold wrong");
   AST_LEVEL_READ: assert property (
      req_i.rd && req_i.addr == TCC_ADDR_LEVEL_C |=> rdata_o == $past(level_q[23:16]))
      else $error("level readback wrong");
   AST_HELD_ZERO: assert property (
      shold_q[2] ##1 shold_q[2] |-> level_q[5:4] == TCC_LVL_NONE)
      else $error("held channel level not zero");
   AST_UPPER_ZERO: assert property (
      req_i.rd && req_i.addr == TCC_ADDR_SHOLD_HI |=> rdata_o[7:4] == 4'h0)
      else $error("upper nibble not zero");
   AST_IRQ_HIGH: assert property (
      irq_level_select_i == TCC_ILS_HIGH && level_q == TCC_RST_LEVEL |=> !irq_o)
      else $error("interrupt without result");
   AST_MODE: assert property (
      output_mode_pin_i [*6] |-> single_mode_o)
      else $error("single mode not followed");
endmodule : tcc_regs
`default_nettype wire

/* tcc_pkg.sv */
/*
 Package for the touch channel control register bank: register offsets,
 reset values, result level codes and the register access carrier.
 Assumes a byte-wide register port fed by the serial interface logic.
*/
`default_nettype none
package tcc_pkg;
   localparam int unsigned TCC_NCH = 12;
   localparam int unsigned TCC_LW = 2;
   localparam int unsigned TCC_LO_W = 8;
   localparam int unsigned TCC_HI_W = 4;
   // Register offsets
   localparam logic [7:0] TCC_ADDR_RENEW_LO = 8'h0a;
   localparam logic [7:0] TCC_ADDR_RENEW_HI = 8'h0b;
   localparam logic [7:0] TCC_ADDR_SHOLD_LO = 8'h0c;
   localparam logic [7:0] TCC_ADDR_SHOLD_HI = 8'h0d;
   localparam logic [7:0] TCC_ADDR_CHOLD_LO = 8'h0e;
   localparam logic [7:0] TCC_ADDR_CHOLD_HI = 8'h0f;
   localparam logic [7:0] TCC_ADDR_LEVEL_A = 8'h10;
   localparam logic [7:0] TCC_ADDR_LEVEL_B = 8'h11;
   localparam logic [7:0] TCC_ADDR_LEVEL_C = 8'h12;
   // Reset values, channel 1 in bit 0
   localparam logic [11:0] TCC_RST_RENEW = 12'hffe;
   localparam logic [11:0] TCC_RST_SHOLD = 12'hffe;
   localparam logic [11:0] TCC_RST_CHOLD = 12'h000;
   localparam logic [23:0] TCC_RST_LEVEL = 24'h000000;
   // Touch result codes
   localparam logic [1:0] TCC_LVL_NONE = 2'h0;
   localparam logic [1:0] TCC_LVL_LOW = 2'h1;
   localparam logic [1:0] TCC_LVL_MID = 2'h2;
   localparam logic [1:0] TCC_LVL_HIGH = 2'h3;
   // Interrupt level select codes
   localparam logic [1:0] TCC_ILS_MID_A = 2'h0;
   localparam logic [1:0] TCC_ILS_LOW = 2'h1;
   localparam logic [1:0] TCC_ILS_MID_B = 2'h2;
   localparam logic [1:0] TCC_ILS_HIGH = 2'h3;
   localparam logic [7:0] TCC_RD_UNMAPPED = 8'h00;
   // Register access request
   typedef struct packed {
      logic wr;
      logic rd;
      logic [7:0] addr;
      logic [7:0] wdata;
   } tcc_req_t;
endpackage : tcc_pkg
`default_nettype wire

/* tcc_sync3.sv */
/*
 Three-stage synchroniser with agreement filter for an asynchronous pin.
 Assumes the pin is static for at least two clocks per change.
*/
`timescale 1ns/1ps
`default_nettype none
module tcc_sync3
   import tcc_pkg::*;
(
   input wire logic clock_i,
   input wire logic rst_i,
   input wire logic pin_i,
   output logic level_o
);
   logic s1_q;
   logic s2_q;
   logic s3_q;
   logic lvl_q;
   logic lvl_d;

   // Accept a change once the second and third stages agree
   always_comb
   begin
      lvl_d = lvl_q;
      if (s2_q == s3_q)
      begin
         lvl_d = s2_q;
      end
   end

   // Sampling stages
   always_ff @(posedge clock_i)
   begin
      if (rst_i)
      begin
         s1_q <= 1'b0;
         s2_q <= 1'b0;
         s3_q <= 1'b0;
         lvl_q <= 1'b0;
      end
      else
      begin
         s1_q <= pin_i;
         s2_q <= s1_q;
         s3_q <= s2_q;
         lvl_q <= lvl_d;
      end
   end

   assign level_o = lvl_q;
endmodule : tcc_sync3
`default_nettype wire

/* tcc_host_model.sv */
/*
 Host model: issues byte register accesses to the register bank.
 Assumes one shared clock and one-cycle request strobes.
*/
`timescale 1ns/1ps
`default_nettype none
module tcc_host_model
   import tcc_pkg::*;
(
   input wire logic clock_i,
   input wire logic [7:0] rdata_i,
   output var tcc_req_t req_o
);
   // Idle request from time zero
   initial req_o = '0;
   // One access, strobe held to its taking edge, data sampled a cycle later
   task automatic access(input logic wr, input logic [7:0] addr, input logic [7:0] wd,
      output logic [7:0] rd);
      @(posedge clock_i);
      req_o <= '{wr: wr, rd: !wr, addr: addr, wdata: wd};
      @(posedge clock_i);
      req_o <= '0;
      @(posedge clock_i);
      #1 rd = rdata_i;
   endtask : access
endmodule : tcc_host_model
`default_nettype wire

/* touch_channel_control_regs_tb_top.sv */
/*
 Self-checking bench for the register bank, with a byte-array model.
 Assumes the host model above and the registered timing of the bank.
*/
`timescale 1ns/1ps
`default_nettype none
module touch_channel_control_regs_tb_top;
   import tcc_pkg::*;
   logic clock_i = 1'b0;
   logic rst_i = 1'b1;
   logic output_mode_pin_i = 1'b0;
   logic [23:0] sense_level_i = '0;
   logic [1:0] irq_level_select_i = '0;
   tcc_req_t req;
   logic [7:0] rdata_o, rd, d;
   logic [11:0] renew_o, sense_en_o, calib_en_o;
   logic single_mode_o, irq_o, e;
   logic [7:0] m [6];
   logic [23:0] lv;
   int n_errors = 0;
   int comparisons = 0;
   int k, thr;
   // Free running clock
   initial forever #5 clock_i = ~clock_i;
   tcc_regs dut_u (.clock_i(clock_i), .rst_i(rst_i), .req_i(req),
      .sense_level_i(sense_level_i), .irq_level_select_i(irq_level_select_i),
      .output_mode_pin_i(output_mode_pin_i), .rdata_o(rdata_o), .renew_o(renew_o),
      .sense_en_o(sense_en_o), .calib_en_o(calib_en_o), .single_mode_o(single_mode_o),
      .irq_o(irq_o));
   tcc_host_model host_u (.clock_i(clock_i), .rdata_i(rdata_o), .req_o(req));
   // Compare and count
   task automatic chk(input string name, input logic [23:0] seen, input logic [23:0] exp);
      comparisons++;
      if (seen !== exp)
      begin
         n_errors++;
         $display("[FAIL] %s expected %h seen %h", name, exp, seen);
      end
   endtask : chk
   // Verdict and end of run
   task automatic tally_and_finish();
      $display("comparisons %0d mismatches %0d", comparisons, n_errors);
      if (n_errors == 0 && comparisons > 0)
         $display("Simulation passed");
      else
         $display("Simulation failed");
      $finish;
   endtask : tally_and_finish
   // Reset for four edges, model back to reset contents
   task automatic do_reset();
      rst_i <= 1'b1;
      repeat (4) @(posedge clock_i);
      rst_i <= 1'b0;
      m = '{8'hfe, 8'h0f, 8'hfe, 8'h0f, 8'h00, 8'h00};
   endtask : do_reset
   // Control outputs against the model once writes have landed
   task automatic check_ctrl();
      repeat (3) @(posedge clock_i);
      #1;
      chk("renew", renew_o, {m[1][3:0], m[0]});
      chk("sense_en", sense_en_o, 12'(~{m[3][3:0], m[2]}));
      chk("calib_en", calib_en_o, 12'(~({m[3][3:0], m[2]} | {m[5][3:0], m[4]})));
   endtask : check_ctrl
   // Main sequence
   initial
   begin
      void'($urandom(32'h4fd0));
      do_reset();
      check_ctrl();
      chk("rdata_rst", rdata_o, 8'h00);
      chk("irq_rst", irq_o, 1'b0);
      $display("test reset done");
      for (int i = 0; i < 18; i++)
      begin
         k = i % 6;
         d = 8'($urandom);
         host_u.access(1'b1, TCC_ADDR_RENEW_LO + 8'(k), d, rd);
         m[k] = (k % 2) ? (d & 8'h0f) : d;
         check_ctrl();
         host_u.access(1'b0, TCC_ADDR_RENEW_LO + 8'(k), 8'h00, rd);
         chk("readback", rd, m[k]);
      end
      $display("test control done");
      for (int s = 0; s < 4; s++)
      begin
         lv = 24'($urandom);
         @(posedge clock_i);
         sense_level_i <= lv;
         irq_level_select_i <= 2'(s);
         thr = (s == 1) ? 1 : (s == 3) ? 3 : 2;
         e = 1'b0;
         for (int c = 0; c < 12; c++)
         begin
            if (c < 8 ? m[2][c] : m[3][c - 8])
               lv[2 * c +: 2] = 2'h0;
            if (lv[2 * c +: 2] >= thr)
               e = 1'b1;
         end
         repeat (3) @(posedge clock_i);
         #1 chk("irq", irq_o, e);
         for (int b = 0; b < 3; b++)
         begin
            host_u.access(1'b0, TCC_ADDR_LEVEL_A + 8'(b), 8'h00, rd);
            chk("level", rd, lv[8 * b +: 8]);
         end
      end
      host_u.access(1'b1, TCC_ADDR_LEVEL_A, ~lv[7:0], rd);
      host_u.access(1'b0, TCC_ADDR_LEVEL_A, 8'h00, rd);
      chk("ro_write", rd, lv[7:0]);
      host_u.access(1'b0, 8'h20, 8'h00, rd);
      chk("unmapped", rd, TCC_RD_UNMAPPED);
      $display("test results done");
      for (int p = 1; p >= 0; p--)
      begin
         @(posedge clock_i);
         output_mode_pin_i <= p[0];
         repeat (8) @(posedge clock_i);
         #1 chk("single_mode", single_mode_o, p);
      end
      $display("test mode done");
      do_reset();
      check_ctrl();
      $display("test mid reset done");
      tally_and_finish();
   end
   // Watchdog well beyond the expected run
   initial
   begin
      repeat (5000) @(posedge clock_i);
      n_errors++;
      tally_and_finish();
   end
endmodule : touch_channel_control_regs_tb_top
`default_nettype wire
